/* File: hw/record_fmt_pkg.sv */
package record_fmt_pkg;
  // ****************************************************
  // Sizes
  // ****************************************************
  localparam int REC_MAX = 15;
  localparam int CHAR_MAX = 8;
  localparam int LEN_W = 4;
  localparam int ADDR_W = 8;
  // ****************************************************
  // Register byte addresses
  // ****************************************************
  localparam logic [7:0] ADDR_EXT_CFG = 8'h00;
  localparam logic [7:0] ADDR_BUF_CAP = 8'h04;
  localparam logic [7:0] ADDR_DESC_CFG = 8'h08;
  localparam logic [7:0] ADDR_POLL_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_POS_XY = 8'h10;
  localparam logic [7:0] ADDR_POS_Z = 8'h14;
  localparam logic [7:0] ADDR_CHAR_LO = 8'h18;
  localparam logic [7:0] ADDR_CHAR_HI = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int EXT_W1 = 0;
  localparam int EXT_W2 = 1;
  localparam int EXT_RD = 2;
  localparam int EXT_NAME = 4;
  localparam int EXT_STAT = 5;
  localparam int EXT_LOC = 6;
  localparam int DESC_EXT = 3;
  localparam int DESC_WIDE = 5;
  localparam int DESC_ABS = 6;
  localparam int POLL_CCNT_LSB = 8;
  // ****************************************************
  // Values
  // ****************************************************
  localparam logic [7:0] LOC_RESERVED = 8'h20;
  localparam logic [31:0] EXT_CFG_RST = 32'h0000_0000;
  localparam logic [16:0] BUF_CAP_RST = 17'h0_0001;
  localparam logic [2:0] CTYPE_NONE = 3'h0;
  typedef enum logic [1:0] {
    CMD_EXT = 2'b01,
    CMD_POLL = 2'b10
  } cmd_type;
endpackage : record_fmt_pkg

/* File: hw/rec_if.sv */
`timescale 1ns/10ps
// Record hand-off from the builder to the byte streamer
interface rec_if;
  import record_fmt_pkg::*;
  logic load;
  logic [7:0] bytes [REC_MAX];
  logic [LEN_W-1:0] len;
  logic busy;
  modport src (output load, output bytes, output len, input busy);
  modport snk (input load, input bytes, input len, output busy);
endinterface : rec_if

/* File: hw/record_streamer.sv */
`timescale 1ns/10ps
module record_streamer #(
  parameter int DEPTH = record_fmt_pkg::REC_MAX
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, low
  input wire logic ce, // Clock enable
  rec_if.snk rif, // Record from builder
  output logic [7:0] out_data, // Record byte
  output logic out_valid, // Byte valid
  output logic out_last, // Last byte of record
  input wire logic out_ready // Link takes byte
);
  import record_fmt_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } st_type;

  st_type st_q;
  logic [7:0] buf_q [DEPTH];
  logic [LEN_W-1:0] len_q;
  logic [LEN_W-1:0] idx_q;
  logic take;

  if (DEPTH != REC_MAX) begin : g_chk
    $error("DEPTH must match the record size");
  end

  assign take = ce && (st_q == ST_IDLE) && rif.load;
  assign rif.busy = (st_q == ST_SEND);

  // ****************************************************
  // Record capture, one slot per byte
  // ****************************************************
  for (genvar g = 0; g < DEPTH; g++) begin : g_buf
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        buf_q[g] <= 8'h00;
      end else if (take) begin
        buf_q[g] <= rif.bytes[g];
      end
    end
  end

  // State; busy holds until the last byte is taken
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
    end else if (ce) begin
      unique case (st_q)
        ST_IDLE: begin
          if (rif.load) st_q <= ST_SEND;
        end
        ST_SEND: begin
          if (out_ready && out_last) st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Output byte; held steady while the link stalls
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_data <= 8'h00;
      out_valid <= 1'b0;
      out_last <= 1'b0;
      idx_q <= '0;
      len_q <= '0;
    end else if (take) begin
      out_data <= rif.bytes[0];
      out_valid <= 1'b1;
      out_last <= (rif.len == LEN_W'(1));
      idx_q <= LEN_W'(1);
      len_q <= rif.len;
    end else if (ce && out_valid && out_ready) begin
      if (out_last) begin
        out_valid <= 1'b0;
        out_last <= 1'b0;
      end else begin
        out_data <= buf_q[idx_q];
        out_last <= (idx_q + LEN_W'(1) == len_q);
        idx_q <= idx_q + LEN_W'(1);
      end
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_stall;
    out_valid && !out_ready;
  endsequence
  sequence s_solo;
    take && rif.len == LEN_W'(1);
  endsequence

  a_stall_hold: assert property (s_stall |=>
    out_valid && $stable(out_data) && $stable(out_last))
    else $error("byte changed while stalled");
  a_solo_end: assert property (s_solo |=>
    out_valid && out_last)
    else $error("header-only record not ended");
  a_last_drop: assert property (
    ce && out_valid && out_last && out_ready |=> !out_valid)
    else $error("valid stayed after last byte");
endmodule : record_streamer

/* File: hw/input_device_record_formatter.sv */
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/10ps
module input_device_record_formatter #(
  parameter int MAX_CHARS = record_fmt_pkg::CHAR_MAX
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, low
  input wire logic ce, // Clock enable, freezes all
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [record_fmt_pkg::ADDR_W-1:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr, // APB error, unmapped
  input wire logic cmd_valid, // Host command strobe
  input wire record_fmt_pkg::cmd_type cmd_code, // Command kind
  input wire logic accept_ok, // Device can take data
  output logic cmd_taken, // Command accepted pulse
  output logic [7:0] rec_data, // Record byte
  output logic rec_valid, // Record byte valid
  output logic rec_last, // Last record byte
  input wire logic rec_ready, // Link takes byte
  output logic [7:0] desc_flags // Basic header bits
);
  import record_fmt_pkg::*;

  if (MAX_CHARS < 1 || MAX_CHARS > CHAR_MAX) begin : g_chk
    $error("MAX_CHARS must lie in 1..8");
  end

  // ****************************************************
  // Register state
  // ****************************************************
  logic [7:0] ext_flags_q;
  logic [6:0] max_rd_q;
  logic [6:0] max_wr_q;
  logic [7:0] loc_q;
  logic [16:0] buf_cap_q;
  logic wide_q;
  logic abs_q;
  logic set2_q;
  logic [2:0] ctype_q;
  logic stat_q;
  logic [1:0] axes_q;
  logic [3:0] ccnt_q;
  logic [31:0] pos_xy_q;
  logic [15:0] pos_z_q;
  logic [63:0] chars_q;
  logic [7:0] sent_q;
  logic [31:0] rd_val;
  logic hit;
  logic wr_en;
  logic go;
  logic poll_go;
  logic [15:0] buf_len;
  logic loc_ok;
  logic [7:0] hdr_ext;
  logic [7:0] hdr_poll;
  logic [2:0] ctype_eff;
  logic [3:0] ccnt_eff;
  logic [15:0] pos [3];
  logic [7:0] bytes_d [REC_MAX];
  logic [LEN_W-1:0] n_d;

  rec_if rif ();

  // ****************************************************
  // APB slave
  // ****************************************************
  // One wait state so read data leaves from a flop
  assign wr_en = ce && psel && penable && pready && pwrite;

  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      ADDR_EXT_CFG: rd_val = {loc_q, 1'b0, max_wr_q, 1'b0, max_rd_q,
                              ext_flags_q};
      ADDR_BUF_CAP: rd_val = {15'h0000, buf_cap_q};
      ADDR_DESC_CFG: rd_val = {24'h00_0000, desc_flags};
      ADDR_POLL_CTRL: rd_val = {20'h0_0000, ccnt_q, set2_q, ctype_q,
                                stat_q, 1'b0, axes_q};
      ADDR_POS_XY: rd_val = pos_xy_q;
      ADDR_POS_Z: rd_val = {16'h0000, pos_z_q};
      ADDR_CHAR_LO: rd_val = chars_q[31:0];
      ADDR_CHAR_HI: rd_val = chars_q[63:32];
      ADDR_STATUS: rd_val = {16'h0000, sent_q, 6'h00,
                             (ccnt_q != 4'h0), rif.busy};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr <= !hit;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Extended describe configuration
  // ****************************************************
  // Reserved header bits are never stored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_flags_q <= EXT_CFG_RST[7:0];
      max_rd_q <= EXT_CFG_RST[14:8];
      max_wr_q <= EXT_CFG_RST[22:16];
      loc_q <= EXT_CFG_RST[31:24];
      buf_cap_q <= BUF_CAP_RST;
    end else if (wr_en) begin
      if (paddr == ADDR_EXT_CFG) begin
        ext_flags_q <= pwdata[7:0] & 8'h77;
        max_rd_q <= pwdata[14:8];
        max_wr_q <= pwdata[22:16];
        loc_q <= pwdata[31:24];
      end
      if (paddr == ADDR_BUF_CAP && pwdata[16:0] != 17'h0_0000) begin
        buf_cap_q <= pwdata[16:0];
      end
    end
  end

  // Basic describe bits; wide shapes poll records, abs is only reported
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wide_q <= 1'b0;
      abs_q <= 1'b0;
    end else if (wr_en && paddr == ADDR_DESC_CFG) begin
      wide_q <= pwdata[DESC_WIDE];
      abs_q <= pwdata[DESC_ABS];
    end
  end

  // Extended support is always answered, so its bit is fixed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      desc_flags <= 8'h00;
    end else if (ce) begin
      desc_flags <= 8'h00;
      desc_flags[DESC_EXT] <= 1'b1;
      desc_flags[DESC_WIDE] <= wide_q;
      desc_flags[DESC_ABS] <= abs_q;
    end
  end

  // ****************************************************
  // Poll data
  // ****************************************************
  // A write to ADDR_POLL_CTRL in the same cycle as a poll wins, so
  // a freshly loaded character count is never wiped.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      set2_q <= 1'b0;
      ctype_q <= CTYPE_NONE;
      stat_q <= 1'b0;
      axes_q <= 2'b00;
      ccnt_q <= 4'h0;
    end else if (ce) begin
      if (poll_go) begin
        ccnt_q <= 4'h0;
        stat_q <= 1'b0;
      end
      if (wr_en && paddr == ADDR_POLL_CTRL) begin
        set2_q <= pwdata[7];
        ctype_q <= pwdata[6:4];
        stat_q <= pwdata[3];
        axes_q <= pwdata[1:0];
        ccnt_q <= (pwdata[11:8] > 4'(MAX_CHARS)) ? 4'(MAX_CHARS)
                  : pwdata[11:8];
      end
    end
  end

  // Positions and character bytes, raw from software
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pos_xy_q <= 32'h0000_0000;
      pos_z_q <= 16'h0000;
      chars_q <= 64'h0000_0000_0000_0000;
    end else if (wr_en) begin
      if (paddr == ADDR_POS_XY) pos_xy_q <= pwdata;
      if (paddr == ADDR_POS_Z) pos_z_q <= pwdata[15:0];
      if (paddr == ADDR_CHAR_LO) chars_q[31:0] <= pwdata;
      if (paddr == ADDR_CHAR_HI) chars_q[63:32] <= pwdata;
    end
  end

  // ****************************************************
  // Record builder
  // ****************************************************
  assign buf_len = 16'(buf_cap_q - 17'h0_0001);
  assign loc_ok = ext_flags_q[EXT_LOC] && (loc_q < LOC_RESERVED);
  assign hdr_ext = {1'b0, loc_ok, ext_flags_q[EXT_STAT],
                    ext_flags_q[EXT_NAME], 1'b0, ext_flags_q[2:0]};
  // A record either has characters of one type or none
  assign ctype_eff = (ccnt_q == 4'h0) ? CTYPE_NONE : ctype_q;
  assign ccnt_eff = (ctype_q == CTYPE_NONE) ? 4'h0 : ccnt_q;
  assign hdr_poll = {set2_q, ctype_eff, stat_q, accept_ok,
                     axes_q};
  assign pos[0] = pos_xy_q[15:0];
  assign pos[1] = pos_xy_q[31:16];
  assign pos[2] = pos_z_q;

  // Pack present fields back to back; nothing pads the tail
  always_comb begin
    n_d = LEN_W'(1);
    for (int i = 0; i < REC_MAX; i++) bytes_d[i] = 8'h00;
    if (cmd_code == CMD_EXT) begin
      bytes_d[0] = hdr_ext;
      if (hdr_ext[EXT_RD]) begin
        bytes_d[n_d] = {1'b0, max_rd_q};
        n_d = n_d + LEN_W'(1);
      end
      if (hdr_ext[EXT_W1] || hdr_ext[EXT_W2]) begin
        bytes_d[n_d] = {1'b0, max_wr_q};
        n_d = n_d + LEN_W'(1);
      end
      if (hdr_ext[EXT_W2]) begin
        bytes_d[n_d] = buf_len[7:0];
        bytes_d[n_d + LEN_W'(1)] = buf_len[15:8];
        n_d = n_d + LEN_W'(2);
      end
      if (loc_ok) begin
        bytes_d[n_d] = loc_q;
        n_d = n_d + LEN_W'(1);
      end
    end else begin
      bytes_d[0] = hdr_poll;
      for (int a = 0; a < 3; a++) begin
        if (a < int'(axes_q)) begin
          bytes_d[n_d] = pos[a][7:0];
          n_d = n_d + LEN_W'(1);
          if (wide_q) begin
            bytes_d[n_d] = pos[a][15:8];
            n_d = n_d + LEN_W'(1);
          end
        end
      end
      // Keycode set 2 codes already carry the release lsb
      for (int c = 0; c < MAX_CHARS; c++) begin
        if (c < int'(ccnt_eff)) begin
          bytes_d[n_d] = chars_q[c*8 +: 8];
          n_d = n_d + LEN_W'(1);
        end
      end
    end
  end

  // ****************************************************
  // Command intake and streaming
  // ****************************************************
  // A command that arrives while a record drains is not taken until the streamer is idle
  assign go = ce && cmd_valid && !rif.busy;
  assign poll_go = go && (cmd_code == CMD_POLL);
  assign rif.load = cmd_valid && !rif.busy;
  assign rif.len = n_d;
  assign rif.bytes = bytes_d;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_taken <= 1'b0;
      sent_q <= 8'h00;
    end else if (ce) begin
      cmd_taken <= go;
      if (go) sent_q <= sent_q + 8'h01;
    end
  end

  record_streamer #(.DEPTH(REC_MAX)) u_stream (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .rif(rif),
    .out_data(rec_data),
    .out_valid(rec_valid),
    .out_last(rec_last),
    .out_ready(rec_ready)
  );

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_ext;
    go && cmd_code == CMD_EXT;
  endsequence
  sequence s_poll;
    go && cmd_code == CMD_POLL;
  endsequence

  a_ext_len: assert property (s_ext |->
    n_d >= LEN_W'(1) && n_d <= LEN_W'(6))
    else $error("extended record length out of range");
  a_ext_resv: assert property (s_ext |->
    !bytes_d[0][7] && !bytes_d[0][3])
    else $error("reserved extended bits set");
  a_loc_code: assert property (s_ext and hdr_ext[EXT_LOC] |->
    bytes_d[n_d - LEN_W'(1)] < LOC_RESERVED)
    else $error("reserved localization code sent");
  a_rd_limit: assert property (s_ext and hdr_ext[EXT_RD] |->
    !bytes_d[1][7])
    else $error("readable register above 127");
  // Low byte sits after header, optional read limit and write limit
  a_buf_bytes: assert property (s_ext and hdr_ext[EXT_W2] |->
    {bytes_d[LEN_W'(2) + LEN_W'(hdr_ext[EXT_RD])],
     bytes_d[LEN_W'(3) + LEN_W'(hdr_ext[EXT_RD])]}
    == {buf_len[7:0], buf_len[15:8]})
    else $error("buffer length bytes wrong");
  a_poll_len: assert property (s_poll |->
    n_d == LEN_W'(1) + LEN_W'(axes_q) * (wide_q ? LEN_W'(2) : LEN_W'(1))
    + ccnt_eff)
    else $error("poll record length wrong");
  a_poll_hdr: assert property (s_poll |->
    bytes_d[0][2] == accept_ok && bytes_d[0][7] == set2_q)
    else $error("poll header flags wrong");
  a_poll_drain: assert property (s_poll ##1 !$past(wr_en) |->
    ccnt_q == 4'h0 && !stat_q)
    else $error("poll data not consumed");
  a_taken_busy: assert property (s_poll or s_ext |=>
    cmd_taken ##0 rif.busy)
    else $error("accepted command not streaming");
endmodule : input_device_record_formatter

/* File: tb/host_link_model.sv */
`timescale 1ns/10ps
// *****************************************
// Host controller and link acceptor model
// *****************************************
module host_link_model (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, low
  input wire logic go, // Issue one command
  input wire record_fmt_pkg::cmd_type code, // Command to issue
  input wire logic slow, // Stall every other cycle
  input wire logic cmd_taken, // Device took command
  output logic cmd_valid, // Command strobe
  output record_fmt_pkg::cmd_type cmd_code, // Command kind
  output logic rec_ready // Link takes byte
);
  // Hold the command until the device reports it taken
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_valid <= 1'b0;
      cmd_code <= record_fmt_pkg::CMD_POLL;
    end else if (go) begin
      cmd_valid <= 1'b1;
      cmd_code <= code;
    end else if (cmd_taken) begin
      cmd_valid <= 1'b0;
    end
  end
  // A slow link alternates, so every byte must survive a stall
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rec_ready <= 1'b0;
    end else begin
      rec_ready <= slow ? !rec_ready : 1'b1;
    end
  end
endmodule : host_link_model

/* File: tb/input_device_record_formatter_bench.sv */
`timescale 1ns/10ps
// *****************************************
// Record formatter bench
// *****************************************
module input_device_record_formatter_bench;
  import record_fmt_pkg::*;
  typedef logic [7:0] bq_type [$];
  logic clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, rec_data, desc_flags;
  logic [31:0] pwdata, prdata, rd;
  logic cmd_valid, accept_ok, cmd_taken, rec_valid, rec_last, rec_ready;
  logic go, slow, last_seen, err;
  cmd_type cmd_code, code;
  bq_type got;
  int miscompares, tests_run;

  input_device_record_formatter dut (.clk(clk), .nrst(nrst), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .accept_ok(accept_ok), .cmd_taken(cmd_taken), .rec_data(rec_data),
    .rec_valid(rec_valid), .rec_last(rec_last), .rec_ready(rec_ready),
    .desc_flags(desc_flags));
  host_link_model host (.clk(clk), .nrst(nrst), .go(go), .code(code),
    .slow(slow), .cmd_taken(cmd_taken), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .rec_ready(rec_ready));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end
  // Collect every byte the link accepts
  always @(posedge clk) begin
    if (rec_valid === 1'b1 && rec_ready === 1'b1) begin
      got.push_back(rec_data);
      if (rec_last === 1'b1) last_seen <= 1'b1;
    end
  end

  task automatic conclude;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  task automatic check_word(string nm, logic [31:0] exp, logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check_word

  // Length first, then every byte in order
  task automatic check_rec(string nm, bq_type exp);
    check_word({nm, " length"}, exp.size(), got.size());
    foreach (exp[i]) begin
      if (i < got.size()) check_word(nm, {24'h0, exp[i]}, {24'h0, got[i]});
    end
  endtask : check_rec

  // APB transfer: hold everything until pready is sampled high
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    // One idle edge, so psel is never lowered and raised at once
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check_word("pready wait", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Issue one command and wait for the closing byte
  task automatic run(cmd_type c, logic s);
    int n;
    got.delete();
    last_seen = 1'b0;
    code <= c;
    slow <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    while (last_seen !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) check_word("record end", 32'h1, 32'h0);
    repeat (2) @(posedge clk);
  endtask : run

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #(20000 * 8);
    miscompares++;
    conclude();
  end

  // *****************************************
  // Main sequence
  // *****************************************
  initial begin
    bq_type e;
    nrst = 1'b0;
    {psel, penable, pwrite, go, slow, accept_ok} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    code = CMD_EXT;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, ADDR_EXT_CFG, 32'h0);
    check_word("ext cfg reset", EXT_CFG_RST, rd);
    apb(1'b0, ADDR_BUF_CAP, 32'h0);
    check_word("buf cap reset", 32'h0000_0001, rd);
    apb(1'b0, 8'h24, 32'h0);
    check_word("unmapped err", 32'h1, {31'h0, err});
    check_word("unmapped data", 32'h0, rd);
    // Bare header, no padding
    run(CMD_EXT, 1'b0);
    check_rec("ext empty", '{8'h00});
    apb(1'b1, ADDR_EXT_CFG, 32'h0000_0030);
    run(CMD_EXT, 1'b0);
    check_rec("ext cmds", '{8'h30});
    // Every field, reserved bits dropped, stalling link
    apb(1'b1, ADDR_EXT_CFG, 32'h1F05_7FFF);
    apb(1'b1, ADDR_BUF_CAP, 32'h0000_0400);
    run(CMD_EXT, 1'b1);
    e = '{8'h77, 8'h7F, 8'h05, 8'hFF, 8'h03, 8'h1F};
    check_rec("ext full", e);
    // Reserved localization code is never reported
    apb(1'b1, ADDR_EXT_CFG, 32'h2005_0A45);
    run(CMD_EXT, 1'b0);
    check_rec("ext loc", '{8'h05, 8'h0A, 8'h05});
    // Wide poll, second set, keycode set 2 with a release code
    apb(1'b1, ADDR_DESC_CFG, 32'h0000_0020);
    // Config lands at the pready edge, the output flop one edge later
    repeat (2) @(posedge clk);
    check_word("desc wide", 32'h28, {24'h0, desc_flags});
    apb(1'b1, ADDR_POS_XY, 32'h5678_1234);
    apb(1'b1, ADDR_POS_Z, 32'h0000_9ABC);
    apb(1'b1, ADDR_CHAR_LO, 32'h0000_2011);
    apb(1'b1, ADDR_POLL_CTRL, 32'h0000_02EB);
    accept_ok <= 1'b1;
    run(CMD_POLL, 1'b1);
    e = '{8'hEF, 8'h34, 8'h12, 8'h78, 8'h56, 8'hBC, 8'h9A, 8'h11, 8'h20};
    check_rec("poll wide", e);
    // Narrow follow-up poll: chars and status request already sent
    apb(1'b1, ADDR_DESC_CFG, 32'h0000_0040);
    repeat (2) @(posedge clk);
    check_word("desc abs", 32'h48, {24'h0, desc_flags});
    accept_ok <= 1'b0;
    run(CMD_POLL, 1'b0);
    check_rec("poll split", '{8'h83, 8'h34, 8'h78, 8'hBC});
    // Every character type, one byte each except type 0 with none, no axes
    accept_ok <= 1'b1;
    for (int t = 0; t < 8; t++) begin
      apb(1'b1, ADDR_CHAR_LO, 32'h40 + t);
      apb(1'b1, ADDR_POLL_CTRL, 32'h0000_0100 | (t << 4));
      run(CMD_POLL, 1'b0);
      e = '{8'h04};
      if (t != 0) e = '{8'h04 | 8'(t << 4), 8'(8'h40 + t)};
      check_rec("poll type", e);
    end
    // Fourteen records sent, idle, no characters left pending
    apb(1'b0, ADDR_STATUS, 32'h0);
    check_word("status", 32'h0000_0E00, rd);
    conclude();
  end
endmodule : input_device_record_formatter_bench
